/* File: apmc_ctrl.sv */
// Overview of operation
// - rise between tenth and sixteenth edge: stay powered, abort, tristate
// - rise between second and tenth edge: partial power-down, abort, tristate
// - rise before second edge keeps normal mode for glitch immunity
// - dummy frame past tenth edge wakes from partial power-down
// - in partial power-down, rise before tenth edge gives full power-down
// - full power-down entry has no glitch protection
// - waking from partial, sampler tracks after first serial edge
// - result shifts as sixteen bits with leading and trailing zeros
// - select fall holds sampler, enables output, starts conversion
`timescale 1ns/100ps
module apmc_ctrl
	import apmc_pkg::*;
(
	// system clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// link clock and frame
	input wire logic i_sclk,
	input wire logic i_cs_n,
	// converter result
	input wire logic [apmc_pkg::APMC_RES_BITS-1:0] i_result,
	// serial result line
	output logic o_serial_result_line,
	output logic o_serial_result_line_oe,
	// power and sampler state
	output logic o_track,
	output apmc_pkg::apmc_mode_t o_mode,
	output logic o_powered,
	output logic o_wake_done
);
	import apmc_pkg::*;

	logic [1:0] rst_ff;
	logic rstn_sys;
	logic cs_sync;
	logic cs_d_ff;
	logic woke_sync;
	logic [4:0] track_edge;
	logic link_track;
	apmc_frame_t frame;
	logic [4:0] edges_snap;
	logic [4:0] edge_p_ff;
	logic [4:0] edge_q_ff;
	logic [4:0] nxt_edge_p;
	logic [4:0] nxt_edge_q;
	logic rise_now;

	apmc_mode_t mode_ff;
	apmc_mode_t nxt_mode;
	logic [4:0] lastcnt_ff;
	logic [4:0] nxt_lastcnt;
	logic [5:0] wake_ff;
	logic [5:0] nxt_wake;
	logic wake_done_ff;
	logic nxt_wake_done;
	logic powered_ff;
	logic nxt_powered;
	logic [1:0] track_ff;

	// reset release through two flops
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_ff <= APMC_SYNC_RST;
		end else begin
			rst_ff <= {rst_ff[0], 1'b1};
		end
	end
	assign rstn_sys = rst_ff[1];

	// sampler release one edge after cs fall when waking from partial
	assign track_edge = (mode_ff == APMC_PARTIAL) ? 5'h01 :
		5'(APMC_RES_BITS + 1);

	apmc_link u_link (
		.i_sclk(i_sclk),
		.i_cs_n(i_cs_n),
		.i_result(i_result),
		.i_track_edge(track_edge),
		.o_serial_result_line(o_serial_result_line),
		.o_serial_result_line_oe(o_serial_result_line_oe),
		.o_track(link_track),
		.o_frame(frame)
	);

	apmc_sync u_cs_sync (
		.i_clk(i_clk_sys),
		.i_rstn(rstn_sys),
		.i_d(i_cs_n),
		.o_q(cs_sync)
	);

	apmc_sync u_woke_sync (
		.i_clk(i_clk_sys),
		.i_rstn(rstn_sys),
		.i_d(frame.woke),
		.o_q(woke_sync)
	);

	// edge count is held steady once sclk stops before cs rises; sample it
	// each system cycle while cs is seen low, keeping the last stable value.
	// limitation: host must stop sclk at least two system clocks before cs
	// rises for the count to be exact.
	// count runs through two flops so it lines up with the cs synchroniser;
	// read raw, the async restart at cs rise would be taken as the count
	always_comb begin
		nxt_edge_p = frame.edges;
		nxt_edge_q = edge_p_ff;
	end

	always_ff @(posedge i_clk_sys or negedge rstn_sys) begin
		if (!rstn_sys) begin
			edge_p_ff <= APMC_CNT_RST;
			edge_q_ff <= APMC_CNT_RST;
		end else begin
			edge_p_ff <= nxt_edge_p;
			edge_q_ff <= nxt_edge_q;
		end
	end

	assign edges_snap = edge_q_ff;
	assign rise_now = cs_sync && !cs_d_ff;

	function automatic apmc_mode_t apmc_next_mode(input apmc_mode_t cur,
		input logic [4:0] cnt);
		apmc_mode_t m;
		m = cur;
		if (cnt >= APMC_NORMAL_EDGES) begin
			m = APMC_NORMAL;
		end else if (cur == APMC_NORMAL) begin
			if (cnt >= APMC_GLITCH_EDGES) begin
				m = APMC_PARTIAL;
			end else begin
				m = APMC_NORMAL;
			end
		end else begin
			m = APMC_FULL;
		end
		return m;
	endfunction

	always_comb begin
		nxt_mode = mode_ff;
		nxt_lastcnt = lastcnt_ff;
		nxt_wake = wake_ff;
		nxt_wake_done = wake_done_ff;
		nxt_powered = powered_ff;
		if (!cs_sync) begin
			nxt_lastcnt = woke_sync ? APMC_NORMAL_EDGES : edges_snap;
		end
		if (rise_now) begin
			nxt_mode = apmc_next_mode(mode_ff, lastcnt_ff);
			nxt_powered = (apmc_next_mode(mode_ff, lastcnt_ff)
				== APMC_NORMAL);
		end
		// wake delay from full power-down counted from cs fall
		if (!cs_sync && cs_d_ff) begin
			nxt_wake = (mode_ff == APMC_FULL) ? APMC_WAKE_CNT : 6'h00;
			nxt_wake_done = (mode_ff != APMC_FULL);
		end else if (wake_ff != 6'h00) begin
			nxt_wake = 6'(wake_ff - 6'h01);
			nxt_wake_done = (wake_ff == 6'h01);
		end
	end

	always_ff @(posedge i_clk_sys or negedge rstn_sys) begin
		if (!rstn_sys) begin
			mode_ff <= APMC_NORMAL;
			lastcnt_ff <= APMC_CNT_RST;
			wake_ff <= 6'h00;
			wake_done_ff <= 1'b1;
			powered_ff <= 1'b1;
			cs_d_ff <= 1'b1;
		end else begin
			mode_ff <= nxt_mode;
			lastcnt_ff <= nxt_lastcnt;
			wake_ff <= nxt_wake;
			wake_done_ff <= nxt_wake_done;
			powered_ff <= nxt_powered;
			cs_d_ff <= cs_sync;
		end
	end

	// registered status outputs
	always_ff @(posedge i_clk_sys or negedge rstn_sys) begin
		if (!rstn_sys) begin
			track_ff <= 2'h0;
		end else begin
			track_ff <= {track_ff[0], link_track};
		end
	end
	assign o_track = track_ff[1];
	assign o_mode = mode_ff;
	assign o_powered = powered_ff;
	assign o_wake_done = wake_done_ff;

	glitch_keep_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_sys)
		rise_now && mode_ff == APMC_NORMAL && lastcnt_ff < APMC_GLITCH_EDGES
		|=> mode_ff == APMC_NORMAL) else $error("glitch rise changed mode");
	partial_entry_a: assert property (@(posedge i_clk_sys)
		disable iff (!rstn_sys)
		rise_now && mode_ff == APMC_NORMAL && lastcnt_ff >= APMC_GLITCH_EDGES
		&& lastcnt_ff < APMC_NORMAL_EDGES |=> mode_ff == APMC_PARTIAL)
		else $error("no partial power-down");
	full_entry_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_sys)
		rise_now && mode_ff != APMC_NORMAL && lastcnt_ff < APMC_NORMAL_EDGES
		|=> mode_ff == APMC_FULL) else $error("no full power-down");
	wake_up_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_sys)
		rise_now && lastcnt_ff >= APMC_NORMAL_EDGES
		|=> mode_ff == APMC_NORMAL && powered_ff)
		else $error("dummy frame did not wake");
	stay_power_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_sys)
		!rise_now |=> $stable(mode_ff)) else $error("mode moved mid frame");
	wake_delay_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_sys)
		$fell(wake_done_ff) |-> ##[39:40] wake_done_ff)
		else $error("wake delay wrong");
	oe_idle_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_sys)
		i_cs_n && cs_sync && cs_d_ff |-> !o_serial_result_line_oe)
		else $error("output driven outside frame");
	powered_mode_a: assert property (@(posedge i_clk_sys)
		disable iff (!rstn_sys)
		powered_ff == (mode_ff == APMC_NORMAL))
		else $error("power flag disagrees");

	sequence full_fall_s;
		!cs_sync && cs_d_ff && mode_ff == APMC_FULL;
	endsequence

	sequence wake_armed_s;
		wake_ff == APMC_WAKE_CNT && !wake_done_ff;
	endsequence

	wake_start_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_sys)
		full_fall_s |=> wake_armed_s) else $error("wake count not armed");
	wake_hold_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_sys)
		wake_ff != 6'h00 |-> !wake_done_ff)
		else $error("wake done while counting");
	count_hold_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_sys)
		cs_sync |=> $stable(lastcnt_ff))
		else $error("count moved outside frame");
	mode_legal_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_sys)
		mode_ff inside {APMC_NORMAL, APMC_PARTIAL, APMC_FULL})
		else $error("illegal mode code");
endmodule

/* File: apmc_pkg.sv */
// shared constants and types for the adc power-mode control block
package apmc_pkg;
	localparam int APMC_RES_BITS = 12;
	localparam int APMC_WORD_BITS = 16;
	localparam logic [4:0] APMC_GLITCH_EDGES = 5'h02;
	localparam logic [4:0] APMC_NORMAL_EDGES = 5'h0a;
	localparam logic [4:0] APMC_WORD_EDGES = 5'h10;
	localparam logic [4:0] APMC_CNT_RST = 5'h00;
	localparam int APMC_CLK_MHZ = 40;
	localparam int APMC_WAKE_DELAY_NS = 1000;
	localparam int APMC_WAKE_CYCLES = (APMC_WAKE_DELAY_NS * APMC_CLK_MHZ + 999)
		/ 1000;
	localparam logic [5:0] APMC_WAKE_CNT = 6'(APMC_WAKE_CYCLES);
	localparam logic [1:0] APMC_SYNC_RST = 2'h0;

	typedef enum logic [1:0] {
		APMC_NORMAL,
		APMC_PARTIAL,
		APMC_FULL
	} apmc_mode_t;

	// frame summary handed from link domain to system domain
	typedef struct packed {
		logic [4:0] edges;
		logic woke;
	} apmc_frame_t;
endpackage

/* File: apmc_sync.sv */
// two-flop synchroniser for a single level
`timescale 1ns/100ps
module apmc_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// level in and out
	input wire logic i_d,
	output logic o_q
);
	logic [1:0] sync_ff;
	logic [1:0] nxt_sync;

	always_comb begin
		nxt_sync = {sync_ff[0], i_d};
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync_ff <= 2'h0;
		end else begin
			sync_ff <= nxt_sync;
		end
	end

	assign o_q = sync_ff[1];
endmodule

/* File: apmc_link.sv */
// serial-clock side: edge counter and result shifter
`timescale 1ns/100ps
module apmc_link
	import apmc_pkg::*;
(
	// link clock and frame
	input wire logic i_sclk,
	input wire logic i_cs_n,
	// result word and sampler release edge
	input wire logic [apmc_pkg::APMC_RES_BITS-1:0] i_result,
	input wire logic [4:0] i_track_edge,
	// serial result line
	output logic o_serial_result_line,
	output logic o_serial_result_line_oe,
	output logic o_track,
	output apmc_pkg::apmc_frame_t o_frame
);
	logic [4:0] edge_ff;
	logic [4:0] nxt_edge;
	logic [APMC_WORD_BITS-1:0] word;

	// cs low is the frame; the count restarts asynchronously when cs rises,
	// so no sclk edge is needed after the frame ends
	always_comb begin
		nxt_edge = edge_ff;
		if (edge_ff != 5'h1f) begin
			nxt_edge = 5'(edge_ff + 5'h01);
		end
	end

	always_ff @(negedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			edge_ff <= APMC_CNT_RST;
		end else begin
			edge_ff <= nxt_edge;
		end
	end

	// bit is picked by the count, so the async restart loads only a constant
	assign word = {2'h0, i_result, 2'h0};
	// output leaves high impedance at cs fall, returns after 16th edge
	assign o_serial_result_line = (edge_ff < APMC_WORD_EDGES) ?
		word[4'hf - edge_ff[3:0]] : 1'b0;
	assign o_serial_result_line_oe = !i_cs_n &&
		(edge_ff < APMC_WORD_EDGES);
	assign o_track = edge_ff >= i_track_edge;
	assign o_frame.edges = edge_ff;
	assign o_frame.woke = edge_ff >= APMC_NORMAL_EDGES;
endmodule

/* File: apmc_host_model.sv */
// host serial master model driving frame select and serial clock
`timescale 1ns/100ps
module apmc_host_model (
	// system clock for pacing
	input wire logic i_clk_sys,
	// serial result line from the device
	input wire logic i_line,
	input wire logic i_line_oe,
	// link clock, frame select and captured word
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_done,
	output logic [15:0] o_word
);
	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_done = 1'b0;
		o_word = 16'h0000;
	end

	// n serial-clock falls; the clock stands high outside frames
	task automatic frame(input int n);
		@(negedge i_clk_sys);
		o_cs_n = 1'b0;
		o_word = 16'h0000;
		// 16 falls give the whole word; fewer end early with no tail
		for (int i = 0; i < n; i++) begin
			#6 o_word = {o_word[14:0], i_line_oe ? i_line : 1'bx};
			o_sclk = 1'b0;
			#6 o_sclk = 1'b1;
		end
		repeat (3) @(negedge i_clk_sys);
		o_cs_n = 1'b1;
		// quiet interval before the next frame, also lets mode settle
		repeat (6) @(negedge i_clk_sys);
		o_done = 1'b1;
		@(negedge i_clk_sys);
		o_done = 1'b0;
	endtask
endmodule

/* File: apmc_ctrl_tb.sv */
// self-checking bench for the adc power-mode control block
`timescale 1ns/100ps
module apmc_ctrl_tb;
	import apmc_pkg::*;
	logic i_clk_sys;
	logic i_rstn;
	logic sclk;
	logic cs_n;
	logic done;
	logic line;
	logic line_oe;
	logic track;
	logic powered;
	logic wake_done;
	logic [APMC_RES_BITS-1:0] result;
	logic [15:0] word;
	apmc_mode_t mode;
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
	apmc_mode_t exp_mode_q[$];
	logic [16:0] exp_word_q[$];

	apmc_ctrl DUT (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_result(result), .o_serial_result_line(line),
		.o_serial_result_line_oe(line_oe), .o_track(track), .o_mode(mode),
		.o_powered(powered), .o_wake_done(wake_done));
	apmc_host_model host (.i_clk_sys(i_clk_sys), .i_line(line),
		.i_line_oe(line_oe), .o_sclk(sclk), .o_cs_n(cs_n), .o_done(done),
		.o_word(word));

	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end

	task automatic compare(input logic [15:0] seen, input logic [15:0] want);
		checks++;
		if (seen !== want) begin
			mismatches++;
			$display("mismatch at %0t: seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one frame of n falls; word is only judged on full awake frames
	task automatic run(input int n, input apmc_mode_t m, input logic wk);
		exp_mode_q.push_back(m);
		exp_word_q.push_back({n == 16 && wk, 2'b00, result, 2'b00});
		host.frame(n);
		compare(16'(wake_done), 16'(wk));
		@(negedge i_clk_sys);
		result = 12'($urandom);
	endtask

	// watcher: each finished frame takes the oldest note off the queues
	always @(posedge i_clk_sys) begin
		logic [16:0] w;
		apmc_mode_t em;
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			mismatches++;
			give_verdict();
		end
		if (done && exp_mode_q.size() > 0) begin
			w = exp_word_q.pop_front();
			em = exp_mode_q.pop_front();
			compare(16'(mode), 16'(em));
			compare(16'(powered), 16'(em == APMC_NORMAL));
			compare(16'(track), 16'h0000);
			compare(16'(line_oe), 16'h0000);
			if (w[16])
				compare(word, w[15:0]);
		end
	end

	initial begin
		void'($urandom(43406));
		i_rstn = 1'b0;
		result = 12'($urandom);
		repeat (20) @(negedge i_clk_sys);
		i_rstn = 1'b1;
		repeat (3) @(negedge i_clk_sys);
		compare(16'(mode), 16'(APMC_NORMAL));
		compare(16'(wake_done), 16'h0001);
		run(16, APMC_NORMAL, 1'b1);
		run(1, APMC_NORMAL, 1'b1);
		run(16, APMC_NORMAL, 1'b1);
		run(2, APMC_PARTIAL, 1'b1);
		run(16, APMC_NORMAL, 1'b1);
		run(10, APMC_NORMAL, 1'b1);
		run(9, APMC_PARTIAL, 1'b1);
		run(9, APMC_FULL, 1'b1);
		run(12, APMC_NORMAL, 1'b0);
		// wake delay must run out before the next real conversion
		repeat (40) @(negedge i_clk_sys);
		compare(16'(wake_done), 16'h0001);
		run(2, APMC_PARTIAL, 1'b1);
		run(1, APMC_FULL, 1'b1);
		run(16, APMC_NORMAL, 1'b0);
		repeat (40) @(negedge i_clk_sys);
		for (int i = 0; i < 6; i++)
			run(10 + ($urandom % 7), APMC_NORMAL, 1'b1);
		run(16, APMC_NORMAL, 1'b1);
		give_verdict();
	end
endmodule
